// File: universal_serial_unit.sv
// three-wire serial shifter with counter, clock select and two-wire hold
`timescale 1ns/1ps
module universal_serial_unit
  import usi_pkg::*;
#(
  parameter int RX_DEPTH = FIFO_DEPTH
)
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // data register access
  input  wire logic              data_wr_i,
  input  wire logic [DATA_W-1:0] data_wdata_i,
  output logic      [DATA_W-1:0] data_o,
  // control register access
  input  wire logic              ctrl_wr_i,
  input  wire logic [7:0]        ctrl_wdata_i,
  output logic      [7:0]        ctrl_o,
  // status register access
  input  wire logic              status_wr_i,
  input  wire logic [7:0]        status_wdata_i,
  output logic      [7:0]        status_o,
  // clock sources
  input  wire logic              timer_match_i,
  input  wire logic              port_toggle_i,
  // serial pins
  input  wire logic              serial_data_in_pin_i,
  input  wire logic              shift_clock_pin_i,
  output logic                   data_out_o,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  output logic                   shift_clock_pin_o,
  output logic                   shift_clock_pin_oe_o,
  // interrupts and wake
  output logic                   ovf_irq_o,
  output logic                   start_irq_o,
  // received byte stream
  output logic                   rx_valid_o,
  output logic      [DATA_W-1:0] rx_data_o,
  input  wire logic              rx_ready_i
);
  // pin synchronisers
  logic [PIN_N-1:0]  sync1_reg;
  logic [PIN_N-1:0]  sync2_reg;
  logic [PIN_N-1:0]  sync3_reg;
  logic [PIN_N-1:0]  pin_lvl_reg;
  logic [PIN_N-1:0]  pin_lvl_next;
  logic [PIN_N-1:0]  pin_raw;

  // core state
  logic [DATA_W-1:0] shift_reg;
  logic [DATA_W-1:0] shift_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic [7:0]        ctrl_reg;
  logic [7:0]        ctrl_next;
  logic              oif_reg;
  logic              oif_next;
  logic              sif_reg;
  logic              sif_next;
  logic              sample_reg;
  logic              sample_next;
  logic              latch_reg;
  logic              latch_next;
  logic              sck_port_reg;
  logic              sck_port_next;
  logic              hold_reg;
  logic              hold_next;

  // derived controls
  logic [1:0]        wire_mode;
  logic              src_ext;
  logic              src_timer;
  logic              edge_sel;
  logic              two_wire;
  logic              sw_shift;
  logic              sw_toggle;
  logic              sck_rise;
  logic              sck_fall;
  logic              sda_fall;
  logic              sample_edge;
  logic              shift_edge;
  logic              shift_evt;
  logic              count_evt;
  logic              shift_ok;
  logic              ovf_evt;
  logic              start_evt;
  logic              latch_open;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;
  logic              rx_valid_reg;
  logic [DATA_W-1:0] rx_data_reg;
  logic              rx_take;

  function automatic logic field(input logic [7:0] v, input int pos);
    field = v[pos];
  endfunction : field

  assign pin_raw[PIN_DI]  = serial_data_in_pin_i;
  assign pin_raw[PIN_SCK] = shift_clock_pin_i;

  // level counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < PIN_N; g++)
    begin : g_pin
      always_comb
      begin
        pin_lvl_next[g] = pin_lvl_reg[g];
        if (sync2_reg[g] == sync3_reg[g])
        begin
          pin_lvl_next[g] = sync3_reg[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1_reg   <= '0;
      sync2_reg   <= '0;
      sync3_reg   <= '0;
      pin_lvl_reg <= '0;
    end
    else
    begin
      sync1_reg   <= pin_raw;
      sync2_reg   <= sync1_reg;
      sync3_reg   <= sync2_reg;
      pin_lvl_reg <= pin_lvl_next;
    end
  end

  assign sck_rise = pin_lvl_next[PIN_SCK] && !pin_lvl_reg[PIN_SCK];
  assign sck_fall = !pin_lvl_next[PIN_SCK] && pin_lvl_reg[PIN_SCK];
  assign sda_fall = !pin_lvl_next[PIN_DI] && pin_lvl_reg[PIN_DI];

  assign wire_mode = ctrl_reg[CTRL_WM_HI:CTRL_WM_LO];
  assign src_ext   = field(ctrl_reg, CTRL_CS1);
  assign src_timer = field(ctrl_reg, CTRL_CS0);
  assign edge_sel  = field(ctrl_reg, CTRL_CS0);
  assign two_wire  = wire_mode[1];
  // strobes act in the cycle of the write itself
  // immediate strobe effect
  assign sw_shift  = ctrl_wr_i && field(ctrl_wdata_i, CTRL_CLK);
  assign sw_toggle = ctrl_wr_i && field(ctrl_wdata_i, CTRL_TC);

  assign sample_edge = edge_sel ? sck_fall : sck_rise;
  assign shift_edge  = edge_sel ? sck_rise : sck_fall;

  always_comb
  begin
    shift_evt = 1'b0;
    count_evt = 1'b0;
    if (src_ext)
    begin
      shift_evt = shift_edge;
      count_evt = field(ctrl_reg, CTRL_CLK) ? sw_toggle : (sck_rise || sck_fall);
    end
    else if (src_timer)
    begin
      shift_evt = timer_match_i;
      count_evt = timer_match_i;
    end
    else
    begin
      shift_evt = sw_shift;
      count_evt = sw_shift;
    end
  end

  // a full receive fifo stalls the shifter until drained
  assign shift_ok  = fifo_in_ready;
  assign ovf_evt   = count_evt && shift_ok && (cnt_reg == CNT_MAX);
  // start is data falling while clock high
  assign start_evt = two_wire && sda_fall && pin_lvl_reg[PIN_SCK];
  // latch open first half external, always internal
  assign latch_open = !src_ext || (pin_lvl_reg[PIN_SCK] == edge_sel);

  always_comb
  begin
    shift_next    = shift_reg;
    cnt_next      = cnt_reg;
    ctrl_next     = ctrl_reg;
    oif_next      = oif_reg;
    sif_next      = sif_reg;
    sample_next   = sample_reg;
    latch_next    = latch_reg;
    sck_port_next = sck_port_reg;
    hold_next     = hold_reg;
    if (ctrl_wr_i)
    begin
      ctrl_next = ctrl_wdata_i;
      ctrl_next[CTRL_TC]  = 1'b0;
      ctrl_next[CTRL_CLK] = field(ctrl_wdata_i, CTRL_CLK) &&
                            field(ctrl_wdata_i, CTRL_CS1);
    end
    if (src_ext && sample_edge)
    begin
      sample_next = pin_lvl_reg[PIN_DI];
    end
    if (data_wr_i)
    begin
      shift_next = data_wdata_i;
    end
    // shift and count on one source, but ext clock with strobe bit counts the toggle strobe
    else if (shift_evt && shift_ok)
    begin
      shift_next = {shift_reg[DATA_W-2:0],
                    src_ext ? sample_reg : pin_lvl_reg[PIN_DI]};
    end
    if (status_wr_i)
    begin
      cnt_next = status_wdata_i[STAT_CNT_LO +: CNT_W];
    end
    else if (count_evt && shift_ok)
    begin
      cnt_next = cnt_reg + 1'b1;
    end
    if (status_wr_i && field(status_wdata_i, STAT_OIF))
    begin
      oif_next = 1'b0;
    end
    if (status_wr_i && field(status_wdata_i, STAT_SIF))
    begin
      sif_next = 1'b0;
    end
    if (ovf_evt)
    begin
      oif_next = 1'b1;
    end
    if (start_evt)
    begin
      sif_next = 1'b1;
    end
    if (latch_open)
    begin
      latch_next = shift_next[DATA_W-1];
    end
    // port bit xor strobe toggles clock, so both in one cycle leave it unchanged
    if (sw_toggle ^ port_toggle_i)
    begin
      sck_port_next = !sck_port_reg;
    end
    // hold clock low after start, or after overflow in two-wire hold mode only
    if (!two_wire)
    begin
      hold_next = 1'b0;
    end
    else if (start_evt || (ovf_evt && wire_mode == WM_TWO_HOLD))
    begin
      hold_next = 1'b1;
    end
    else if (!sif_next && !oif_next)
    begin
      hold_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      shift_reg    <= DATA_RST;
      cnt_reg      <= CNT_RST;
      ctrl_reg     <= CTRL_RST;
      oif_reg      <= 1'b0;
      sif_reg      <= 1'b0;
      sample_reg   <= 1'b0;
      latch_reg    <= 1'b0;
      sck_port_reg <= 1'b0;
      hold_reg     <= 1'b0;
    end
    else
    begin
      shift_reg    <= shift_next;
      cnt_reg      <= cnt_next;
      ctrl_reg     <= ctrl_next;
      oif_reg      <= oif_next;
      sif_reg      <= sif_next;
      sample_reg   <= sample_next;
      latch_reg    <= latch_next;
      sck_port_reg <= sck_port_next;
      hold_reg     <= hold_next;
    end
  end

  byte_fifo
  #(
    .WIDTH (DATA_W),
    .DEPTH (RX_DEPTH)
  )
  u_rx_fifo
  (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (ovf_evt),
    .in_data_i   (shift_next),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_data),
    .out_ready_i (rx_take)
  );

  // output stage keeps the stream port registered
  assign rx_take = fifo_out_valid && (!rx_valid_reg || rx_ready_i);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_valid_reg <= 1'b0;
      rx_data_reg  <= DATA_RST;
    end
    else
    begin
      if (rx_take)
      begin
        rx_valid_reg <= 1'b1;
        rx_data_reg  <= fifo_out_data;
      end
      else if (rx_ready_i)
      begin
        rx_valid_reg <= 1'b0;
      end
    end
  end

  // registered pin and flag outputs
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      data_out_o           <= 1'b0;
      sda_o                <= 1'b0;
      sda_oe_o             <= 1'b0;
      shift_clock_pin_o    <= 1'b0;
      shift_clock_pin_oe_o <= 1'b0;
      ovf_irq_o            <= 1'b0;
      start_irq_o          <= 1'b0;
    end
    else
    begin
      data_out_o           <= (wire_mode == WM_THREE) && latch_next;
      sda_o                <= 1'b0;
      sda_oe_o             <= two_wire && !latch_next;
      shift_clock_pin_o    <= sck_port_next && !hold_next;
      shift_clock_pin_oe_o <= hold_next || (two_wire && !sck_port_next);
      ovf_irq_o            <= oif_next && field(ctrl_next, CTRL_OIE);
      start_irq_o          <= sif_next && field(ctrl_next, CTRL_SIE);
    end
  end

  assign data_o     = shift_reg;
  assign ctrl_o     = ctrl_reg;
  assign status_o   = {sif_reg, oif_reg, 2'b00, cnt_reg};
  assign rx_valid_o = rx_valid_reg;
  assign rx_data_o  = rx_data_reg;
endmodule : universal_serial_unit

// File: usi_pkg.sv
// constants and field layout for the three-wire serial shifter
//
// Overview of operation
// - processor-accessible 8-bit shift register drives output pin
// - latch makes output change on opposite edge
// - input always sampled from data-in pin
// - readable writable 4-bit counter with overflow interrupt
// - register and counter advance together on timer match or strobe clock
// - external clock counts both edges
// - clock from pin, timer match or strobe
// - two-wire start interrupt and clock hold
// - three-wire follows SPI modes 0/1, no select
// - eight clocks exchange master and slave bytes
// - master clock pin toggles by port or strobe, not both in one cycle
// - edge select picks sample and shift edges
// - sixteen edges overflow counter and set flag
// - overflow interrupt wakes from idle
// - status write with flag bit one clears flag, loads counter
// - alternating control writes act at once
// - start detection wakes from every sleep
// - data write beats simultaneous shift
// - latch open first half external, always internal
package usi_pkg;
  localparam int          DATA_W      = 8;
  localparam int          CNT_W       = 4;
  localparam int          FIFO_DEPTH  = 16;
  localparam int          CLK_MHZ     = 25;
  localparam int          CLK_NS      = 40;
  localparam logic [3:0]  CNT_MAX     = 4'hF;
  localparam logic [3:0]  CNT_RST     = 4'h0;
  localparam logic [7:0]  DATA_RST    = 8'h00;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  // control fields
  localparam int          CTRL_TC     = 0;
  localparam int          CTRL_CLK    = 1;
  localparam int          CTRL_CS0    = 2;
  localparam int          CTRL_CS1    = 3;
  localparam int          CTRL_WM_LO  = 4;
  localparam int          CTRL_WM_HI  = 5;
  localparam int          CTRL_OIE    = 6;
  localparam int          CTRL_SIE    = 7;
  // status fields
  localparam int          STAT_CNT_LO = 0;
  localparam int          STAT_OIF    = 6;
  localparam int          STAT_SIF    = 7;
  // wire modes
  localparam logic [1:0]  WM_NONE     = 2'h0;
  localparam logic [1:0]  WM_THREE    = 2'h1;
  localparam logic [1:0]  WM_TWO      = 2'h2;
  localparam logic [1:0]  WM_TWO_HOLD = 2'h3;
  // pin sync vector positions
  localparam int          PIN_DI      = 0;
  localparam int          PIN_SCK     = 1;
  localparam int          PIN_N       = 2;
endpackage : usi_pkg

// File: byte_fifo.sv
// fifo holding received bytes
`timescale 1ns/1ps
module byte_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // drain side
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW-1:0]    rd_ptr_next;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic             push;
  logic             pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = (count_reg != CW'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem[rd_ptr_reg];

  always_comb
  begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push)
    begin
      wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop)
    begin
      rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (push && !pop)
    begin
      count_next = count_reg + 1'b1;
    end
    else if (pop && !push)
    begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end
endmodule : byte_fifo

// File: serial_unit_chk.sv
// port assertions for the serial shifter
`timescale 1ns/1ps
module serial_unit_chk
  import usi_pkg::*;
#(
  parameter int RX_DEPTH = FIFO_DEPTH
)
(
  // clock and reset
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  // register access
  input wire logic              data_wr_i,
  input wire logic [DATA_W-1:0] data_wdata_i,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic              ctrl_wr_i,
  input wire logic [7:0]        ctrl_wdata_i,
  input wire logic [7:0]        ctrl_o,
  input wire logic              status_wr_i,
  input wire logic [7:0]        status_wdata_i,
  input wire logic [7:0]        status_o,
  // clock sources and outputs
  input wire logic              timer_match_i,
  input wire logic              port_toggle_i,
  input wire logic              shift_clock_pin_o,
  input wire logic              ovf_irq_o,
  // byte stream
  input wire logic              rx_valid_o,
  input wire logic [DATA_W-1:0] rx_data_o,
  input wire logic              rx_ready_i
);
  logic tgl;
  assign tgl = port_toggle_i ^ (ctrl_wr_i && ctrl_wdata_i[CTRL_TC]);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // internal strobe or timer event with nothing competing
  sequence s_int_ev;
    !data_wr_i && !status_wr_i && !rx_valid_o && !ctrl_o[CTRL_CS1] &&
    ((ctrl_wr_i && ctrl_wdata_i[CTRL_CLK] && !ctrl_o[CTRL_CS0] &&
      !timer_match_i) ||
     (timer_match_i && ctrl_o[CTRL_CS0] && !ctrl_wr_i));
  endsequence
  sequence s_last_count;
    s_int_ev ##0 status_o[3:0] == CNT_MAX;
  endsequence
  AST_DATA_WR: assert property (data_wr_i |=> data_o == $past(data_wdata_i))
    else $error("data write not taken");
  AST_SHIFT: assert property (s_int_ev |=> data_o[7:1] == $past(data_o[6:0])
    && status_o[3:0] == $past(status_o[3:0]) + 4'h1)
    else $error("shift and count not together");
  AST_OVF: assert property (s_last_count |=>
    status_o[STAT_OIF] && status_o[3:0] == CNT_RST)
    else $error("overflow not flagged");
  AST_LOAD: assert property (status_wr_i |=>
    status_o[3:0] == $past(status_wdata_i[3:0]))
    else $error("counter not loaded");
  AST_CLR: assert property (status_wr_i && status_wdata_i[STAT_OIF] &&
    !ctrl_wr_i && !timer_match_i && !ctrl_o[CTRL_CS1] |=> !status_o[STAT_OIF])
    else $error("flag not cleared");
  AST_STICKY: assert property (status_o[STAT_OIF] && !status_wr_i |=>
    status_o[STAT_OIF])
    else $error("flag dropped");
  AST_IRQ_ON: assert property (status_o[STAT_OIF] && ctrl_o[CTRL_OIE] &&
    !status_wr_i && !ctrl_wr_i |=> ovf_irq_o)
    else $error("irq missing");
  AST_IRQ_OFF: assert property (!ctrl_o[CTRL_OIE] &&
    !$past(ctrl_o[CTRL_OIE]) |-> !ovf_irq_o)
    else $error("irq while masked");
  AST_TOGGLE: assert property (!ctrl_o[CTRL_WM_HI] &&
    !$past(ctrl_o[CTRL_WM_HI]) &&
    !(ctrl_wr_i && ctrl_wdata_i[CTRL_WM_HI]) |=>
    shift_clock_pin_o == ($past(shift_clock_pin_o) ^ $past(tgl)))
    else $error("clock pin toggle wrong");
  AST_HOLD: assert property (rx_valid_o && !rx_ready_i |=>
    rx_valid_o && $stable(rx_data_o))
    else $error("stream byte not held");
endmodule : serial_unit_chk

bind universal_serial_unit serial_unit_chk #(.RX_DEPTH(RX_DEPTH))
  i_serial_unit_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .data_wr_i(data_wr_i), .data_wdata_i(data_wdata_i), .data_o(data_o),
  .ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i), .ctrl_o(ctrl_o),
  .status_wr_i(status_wr_i), .status_wdata_i(status_wdata_i),
  .status_o(status_o), .timer_match_i(timer_match_i),
  .port_toggle_i(port_toggle_i), .shift_clock_pin_o(shift_clock_pin_o),
  .ovf_irq_o(ovf_irq_o), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
  .rx_ready_i(rx_ready_i));

// File: remote_spi_master.sv
// remote mode 0 master on the link pins
`timescale 1ns/1ps
module remote_spi_master
#(
  parameter int HALF_NS = 160
)
(
  // link pins
  output logic      sck_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  initial
  begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
  end
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      mosi_o = tx[7 - i];
      #(HALF_NS);
      sck_o = 1'b1;
      #(HALF_NS);
      rx = {rx[6:0], miso_i};
      sck_o = 1'b0;
    end
    #(HALF_NS);
    mosi_o = ~mosi_o;
  endtask : xfer
  // start: data falls while clock high
  task automatic start_cond;
    mosi_o = 1'b1;
    sck_o = 1'b1;
    #(HALF_NS);
    mosi_o = 1'b0;
    #(HALF_NS);
    sck_o = 1'b0;
    #(HALF_NS);
  endtask : start_cond
endmodule : remote_spi_master

// File: tb.sv
// self-checking bench for the serial shifter
`timescale 1ns/1ps
module tb;
  import usi_pkg::*;
  localparam logic [2:0] D = 3'b001, C = 3'b010, S = 3'b100;
  logic       clk_i = 1'b0, rst_n_i = 1'b0;
  logic       data_wr_i = 1'b0, ctrl_wr_i = 1'b0, status_wr_i = 1'b0;
  logic [7:0] data_wdata_i = 8'h00, ctrl_wdata_i = 8'h00;
  logic [7:0] status_wdata_i = 8'h00;
  logic       timer_match_i = 1'b0, port_toggle_i = 1'b0, rx_ready_i = 1'b1;
  logic [7:0] data_o, ctrl_o, status_o, rx_data_o;
  logic       data_out_o, shift_clock_pin_o, ovf_irq_o, rx_valid_o;
  logic       start_irq_o, shift_clock_pin_oe_o;
  wire        di, sck;
  int         bad_count = 0, checks = 0;
  logic [7:0] lf = 8'h0E, e, d, r1, r2;
  logic [7:0] q[$];
  always #20 clk_i = ~clk_i;
  universal_serial_unit i_universal_serial_unit (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .data_wr_i(data_wr_i),
    .data_wdata_i(data_wdata_i), .data_o(data_o), .ctrl_wr_i(ctrl_wr_i),
    .ctrl_wdata_i(ctrl_wdata_i), .ctrl_o(ctrl_o), .status_wr_i(status_wr_i),
    .status_wdata_i(status_wdata_i), .status_o(status_o),
    .timer_match_i(timer_match_i), .port_toggle_i(port_toggle_i),
    .serial_data_in_pin_i(di), .shift_clock_pin_i(sck),
    .data_out_o(data_out_o), .sda_o(), .sda_oe_o(),
    .shift_clock_pin_o(shift_clock_pin_o),
    .shift_clock_pin_oe_o(shift_clock_pin_oe_o),
    .ovf_irq_o(ovf_irq_o), .start_irq_o(start_irq_o),
    .rx_valid_o(rx_valid_o),
    .rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i));
  remote_spi_master i_remote_spi_master (.sck_o(sck), .mosi_o(di),
    .miso_i(data_out_o));
  function automatic logic [7:0] next_lf(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : next_lf
  function automatic logic [7:0] shl(input logic [7:0] v, input logic b);
    return {v[6:0], b};
  endfunction : shl
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask : tick
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] k, input logic [7:0] v);
    {status_wr_i, ctrl_wr_i, data_wr_i} = k;
    data_wdata_i = v;
    ctrl_wdata_i = v;
    status_wdata_i = v;
    tick;
    {status_wr_i, ctrl_wr_i, data_wr_i} = 3'b000;
    tick;
  endtask : wr
  task automatic wait_rx;
    for (int i = 0; i < 40 && rx_valid_o !== 1'b1; i++)
      tick;
    if (rx_valid_o !== 1'b1)
    begin
      bad_count++;
      complete_run;
    end
  endtask : wait_rx
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (6) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    tick;
    d = lf;
    wr(D, d);
    e = d;
    ctrl_wr_i = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      ctrl_wdata_i = i[0] ? 8'h13 : 8'h11;
      if (i[0])
        e = shl(e, di);
      tick;
      chk({7'h00, shift_clock_pin_o}, {7'h00, ~i[0]});
      chk(data_o, e);
      chk({4'h0, status_o[3:0]}, 8'((i + 1) / 2));
    end
    ctrl_wr_i = 1'b0;
    port_toggle_i = 1'b1;
    tick;
    port_toggle_i = 1'b0;
    chk({7'h00, shift_clock_pin_o}, 8'h01);
    wr(S, 8'h4F);
    chk(status_o, 8'h0F);
    wr(C, 8'h12);
    chk(status_o, 8'h40);
    wait_rx;
    chk(rx_data_o, shl(e, di));
    wr(C, 8'h50);
    chk({7'h00, ovf_irq_o}, 8'h01);
    wr(C, 8'h10);
    chk({7'h00, ovf_irq_o}, 8'h00);
    wr(S, 8'h40);
    chk(status_o, 8'h00);
    $display("test strobe done");
    wr(C, 8'h14);
    lf = next_lf(lf);
    for (int i = 0; i <= lf[2:0]; i++)
    begin
      timer_match_i = 1'b1;
      tick;
      timer_match_i = 1'b0;
      tick;
    end
    chk(status_o, {5'h00, lf[2:0]} + 8'h01);
    timer_match_i = 1'b1;
    wr(D | C, 8'h12);
    timer_match_i = 1'b0;
    chk(data_o, 8'h12);
    $display("test timer done");
    wr(C, 8'h18);
    lf = next_lf(lf);
    d = lf;
    wr(D, d);
    wr(S, 8'h40);
    lf = next_lf(lf);
    rx_ready_i = 1'b0;
    i_remote_spi_master.xfer(lf, 4, r1);
    repeat (6) tick;
    chk(status_o, 8'h08);
    i_remote_spi_master.xfer(lf << 4, 4, r2);
    repeat (6) tick;
    chk(status_o, 8'h40);
    chk(data_o, lf);
    chk({r1[3:0], r2[3:0]}, d);
    wait_rx;
    chk(rx_data_o, lf);
    $display("test link done");
    rx_ready_i = 1'b1;
    wr(C, 8'h10);
    rx_ready_i = 1'b0;
    for (int i = 0; i < 18; i++)
    begin
      lf = next_lf(lf);
      wr(D, lf);
      wr(S, 8'h4F);
      wr(C, 8'h12);
      if (i < 17)
        q.push_back(shl(lf, di));
    end
    chk(data_o, lf);
    chk(status_o, 8'h0F);
    while (q.size() > 0)
    begin
      wait_rx;
      chk(rx_data_o, q.pop_front());
      rx_ready_i = 1'b1;
      tick;
      rx_ready_i = 1'b0;
      tick;
    end
    $display("test fifo done");
    wr(C, 8'hA0);
    i_remote_spi_master.start_cond;
    tick;
    chk({6'h00, start_irq_o, status_o[STAT_SIF]}, 8'h03);
    chk({6'h00, shift_clock_pin_oe_o, shift_clock_pin_o}, 8'h02);
    wr(S, 8'h80);
    chk({6'h00, shift_clock_pin_oe_o, shift_clock_pin_o}, 8'h01);
    $display("test start done");
    complete_run;
  end
endmodule : tb
